// File: rx_event_status_interrupt_unit.sv
// Receive event latches, masks, summary and interrupt output
`default_nettype none

module rx_event_status_interrupt_unit #(
    parameter int unsigned MF_FREE_CYCLES = rx_event_pkg::E1_MULTIFRAME_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Host port
    input  wire logic [7:0]  hostAddr,
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    input  wire logic [7:0]  hostWriteData,
    output var  logic [7:0]  hostReadData,
    // Framer context
    input  wire logic        t1Mode,
    input  wire logic        esfMode,
    input  wire logic        casEnabled,
    input  wire logic        multiframeBoundary,
    // HDLC receiver
    input  wire logic        hdlcOverrunAbort,
    input  wire logic        hdlcFirstByteAtHead,
    input  wire logic        hdlcPacketDone,
    input  wire logic        hdlcPacketFault,
    input  wire logic        hdlcOpeningByte,
    input  wire logic        hdlcAboveHighMark,
    input  wire logic        hdlcFifoNonempty,
    // Code, link and Sa detectors
    input  wire logic        remoteAlarmPresent,
    input  wire logic        raiCiPattern,
    input  wire logic        aisPresent,
    input  wire logic        aisCiPattern,
    input  wire logic        slcAlignFound,
    input  wire logic        slcDataReady,
    input  wire logic        dataLinkHoldingFull,
    input  wire logic        bitCodeValid,
    input  wire logic        bitCodeGone,
    input  wire logic        sa6Codeword,
    input  wire logic [4:0]  saBitToggle,
    input  wire logic [4:0]  saBitSelectMask,
    // Signaling and other status sources
    input  wire logic [31:0] signalingToggle,
    input  wire logic [7:0]  latchedStatusOne,
    input  wire logic [7:0]  latchedStatusTwo,
    input  wire logic        statusThreePending,
    // Spare code detector side and interrupt output
    input  wire logic [4:0]  spareLength,
    output var  logic [15:0] sparePattern,
    output var  logic [15:0] spareCareMask,
    output var  logic        spareIntegrationRestart,
    output var  logic        interruptOutN
);

    logic [7:0]  rxLatchedStatusFour;
    logic [7:0]  rxHdlcEventLatch;
    logic [7:0]  rxCodeLinkEventLatch;
    logic [31:0] rxSigChange;
    logic [7:0]  sparePatternDefFirst;
    logic [7:0]  sparePatternDefSecond;
    logic [7:0]  rxAlarmInterruptMask;
    logic [7:0]  rxE1FrameEventMask;
    logic [7:0]  rxMaskFour;
    logic [7:0]  rxMaskHdlc;
    logic [7:0]  rxMaskCode;
    logic [31:0] signalingChangeEnable;
    logic [7:0]  rxInterruptSourceSummary;
    logic        prevAboveHighMark;
    logic        prevFifoNonempty;
    logic [31:0] freeCount;
    logic        freeTick;
    logic        multiframeEvent;
    logic        signalingChangeSummary;
    logic [31:0] channelLive;
    logic [7:0]  setFour;
    logic [7:0]  setHdlc;
    logic [7:0]  setCode;
    logic        readFour;
    logic        readHdlc;
    logic        readCode;
    logic [3:0]  readSig;

    ////////////////////////////////////////////////////////////////////////////
    // Multiframe timing

    // Free-running boundary only counts while E1 runs without CAS
    always_ff @(posedge clock) begin
        if (!reset_n || t1Mode || casEnabled) begin
            freeCount <= 32'h0000_0000;
        end else if (freeTick) begin
            freeCount <= 32'h0000_0000;
        end else begin
            freeCount <= freeCount + 32'h0000_0001;
        end
    end

    assign freeTick = !t1Mode && !casEnabled && (freeCount == 32'(MF_FREE_CYCLES - 1));

    always_comb begin
        if (t1Mode) begin
            multiframeEvent = multiframeBoundary;
        end else begin
            multiframeEvent = casEnabled ? multiframeBoundary : freeTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event sources

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prevAboveHighMark <= 1'b0;
            prevFifoNonempty  <= 1'b0;
        end else begin
            prevAboveHighMark <= hdlcAboveHighMark;
            prevFifoNonempty  <= hdlcFifoNonempty;
        end
    end

    // Channels 25 to 32 exist only in E1
    assign channelLive = t1Mode ? 32'h00FF_FFFF : 32'hFFFF_FFFF;
    assign signalingChangeSummary = |(signalingToggle & channelLive & signalingChangeEnable);

    always_comb begin
        setFour = 8'h00;
        setFour[rx_event_pkg::BIT_MULTIFRAME]  = multiframeEvent;
        setFour[rx_event_pkg::BIT_SIG_SUMMARY] = signalingChangeSummary;
    end

    always_comb begin
        setHdlc = 8'h00;
        setHdlc[rx_event_pkg::BIT_OVERRUN]      = hdlcOverrunAbort;
        setHdlc[rx_event_pkg::BIT_FIRST_BYTE]   = hdlcFirstByteAtHead;
        setHdlc[rx_event_pkg::BIT_PACKET_END]   = hdlcPacketDone || hdlcPacketFault;
        setHdlc[rx_event_pkg::BIT_PACKET_START] = hdlcOpeningByte;
        setHdlc[rx_event_pkg::BIT_HIGH_MARK]    = hdlcAboveHighMark && !prevAboveHighMark;
        setHdlc[rx_event_pkg::BIT_NONEMPTY]     = hdlcFifoNonempty && !prevFifoNonempty;
    end

    // Bits 1 and 0 mean different events in T1 and E1
    always_comb begin
        setCode = 8'h00;
        if (t1Mode) begin
            setCode[rx_event_pkg::BIT_REMOTE_CI]   = raiCiPattern && esfMode && remoteAlarmPresent;
            setCode[rx_event_pkg::BIT_AIS_CI]      = aisCiPattern && aisPresent;
            setCode[rx_event_pkg::BIT_SLC_ALIGN]   = slcAlignFound && slcDataReady;
            setCode[rx_event_pkg::BIT_LINK_FULL]   = dataLinkHoldingFull;
            setCode[rx_event_pkg::BIT_CODE_CLEAR]  = bitCodeGone;
            setCode[rx_event_pkg::BIT_CODE_DETECT] = bitCodeValid;
        end else begin
            setCode[rx_event_pkg::BIT_SA6_CODEWORD] = sa6Codeword;
            setCode[rx_event_pkg::BIT_SA_CHANGE]    = |(saBitToggle & saBitSelectMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched status registers

    assign readFour = hostRead && (hostAddr == rx_event_pkg::ADDR_STATUS_FOUR);
    assign readHdlc = hostRead && (hostAddr == rx_event_pkg::ADDR_HDLC_EVENT);
    assign readCode = hostRead && (hostAddr == rx_event_pkg::ADDR_CODE_LINK);

    rx_sticky_bank #(.WIDTH(8)) u_status_four (
        .clock     (clock),
        .reset_n   (reset_n),
        .setEvent  (setFour),
        .readClear (readFour),
        .status    (rxLatchedStatusFour)
    );

    rx_sticky_bank #(.WIDTH(8)) u_hdlc_event (
        .clock     (clock),
        .reset_n   (reset_n),
        .setEvent  (setHdlc),
        .readClear (readHdlc),
        .status    (rxHdlcEventLatch)
    );

    rx_sticky_bank #(.WIDTH(8)) u_code_link (
        .clock     (clock),
        .reset_n   (reset_n),
        .setEvent  (setCode),
        .readClear (readCode),
        .status    (rxCodeLinkEventLatch)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sig
            assign readSig[g] = hostRead && (hostAddr == rx_event_pkg::ADDR_SIG_CHANGE0 + 8'(g));
            rx_sticky_bank #(.WIDTH(8)) u_sig_change (
                .clock     (clock),
                .reset_n   (reset_n),
                .setEvent  (signalingToggle[8*g +: 8] & channelLive[8*g +: 8]),
                .readClear (readSig[g]),
                .status    (rxSigChange[8*g +: 8])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rxAlarmInterruptMask  <= rx_event_pkg::RESET_BYTE;
            rxE1FrameEventMask    <= rx_event_pkg::RESET_BYTE;
            rxMaskFour            <= rx_event_pkg::RESET_BYTE;
            rxMaskHdlc            <= rx_event_pkg::RESET_BYTE;
            rxMaskCode            <= rx_event_pkg::RESET_BYTE;
        end else if (hostWrite) begin
            unique case (hostAddr)
                rx_event_pkg::ADDR_MASK_ONE:  rxAlarmInterruptMask <= hostWriteData;
                rx_event_pkg::ADDR_MASK_TWO:  rxE1FrameEventMask   <= hostWriteData & rx_event_pkg::USED_MASK_TWO;
                rx_event_pkg::ADDR_MASK_FOUR: rxMaskFour           <= hostWriteData & rx_event_pkg::USED_MASK_FOUR;
                rx_event_pkg::ADDR_MASK_HDLC: rxMaskHdlc           <= hostWriteData & rx_event_pkg::USED_HDLC;
                rx_event_pkg::ADDR_MASK_CODE: rxMaskCode           <= hostWriteData & rx_event_pkg::USED_CODE_LINK;
                default: ;
            endcase
        end
    end

    generate
        for (g = 0; g < 4; g++) begin : g_enable
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    signalingChangeEnable[8*g +: 8] <= rx_event_pkg::RESET_BYTE;
                end else if (hostWrite && hostAddr == rx_event_pkg::ADDR_SIG_ENABLE0 + 8'(g)) begin
                    signalingChangeEnable[8*g +: 8] <= hostWriteData;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Spare code definition

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sparePatternDefFirst    <= rx_event_pkg::RESET_BYTE;
            sparePatternDefSecond   <= rx_event_pkg::RESET_BYTE;
            spareIntegrationRestart <= 1'b0;
        end else begin
            if (hostWrite && hostAddr == rx_event_pkg::ADDR_SPARE_FIRST) begin
                sparePatternDefFirst <= hostWriteData;
            end
            if (hostWrite && hostAddr == rx_event_pkg::ADDR_SPARE_SECOND) begin
                sparePatternDefSecond <= hostWriteData;
            end
            spareIntegrationRestart <= hostWrite && hostAddr == rx_event_pkg::ADDR_SPARE_FIRST;
        end
    end

    // Pattern starts at bit 7 of the first register; bits past the length are don't care
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            spareCareMask <= 16'h0000;
            sparePattern  <= 16'h0000;
        end else begin
            if (spareLength >= 5'd16) begin
                spareCareMask <= 16'hFFFF;
                sparePattern  <= {sparePatternDefFirst, sparePatternDefSecond};
            end else begin
                spareCareMask <= 16'hFFFF << (5'd16 - spareLength);
                sparePattern  <= {sparePatternDefFirst, sparePatternDefSecond}
                                 & (16'hFFFF << (5'd16 - spareLength));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary and interrupt

    always_comb begin
        rxInterruptSourceSummary = 8'h00;
        rxInterruptSourceSummary[rx_event_pkg::SUM_STATUS_ONE]   = |(latchedStatusOne & rxAlarmInterruptMask);
        rxInterruptSourceSummary[rx_event_pkg::SUM_STATUS_TWO]   =
            !t1Mode && |(latchedStatusTwo & rxE1FrameEventMask);
        rxInterruptSourceSummary[rx_event_pkg::SUM_STATUS_THREE] = statusThreePending;
        rxInterruptSourceSummary[rx_event_pkg::SUM_STATUS_FOUR]  = |(rxLatchedStatusFour & rxMaskFour);
        rxInterruptSourceSummary[rx_event_pkg::SUM_HDLC]         = |(rxHdlcEventLatch & rxMaskHdlc);
        rxInterruptSourceSummary[rx_event_pkg::SUM_CODE_LINK]    = |(rxCodeLinkEventLatch & rxMaskCode);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            interruptOutN <= 1'b1;
        end else begin
            interruptOutN <= ~|rxInterruptSourceSummary;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path; data shows the value before any clear

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hostReadData <= rx_event_pkg::RESET_BYTE;
        end else if (hostRead) begin
            unique case (hostAddr)
                rx_event_pkg::ADDR_STATUS_FOUR:  hostReadData <= rxLatchedStatusFour & rx_event_pkg::USED_STATUS_FOUR;
                rx_event_pkg::ADDR_HDLC_EVENT:   hostReadData <= rxHdlcEventLatch;
                rx_event_pkg::ADDR_CODE_LINK:    hostReadData <= rxCodeLinkEventLatch;
                rx_event_pkg::ADDR_SIG_CHANGE0:  hostReadData <= rxSigChange[7:0];
                rx_event_pkg::ADDR_SIG_CHANGE1:  hostReadData <= rxSigChange[15:8];
                rx_event_pkg::ADDR_SIG_CHANGE2:  hostReadData <= rxSigChange[23:16];
                rx_event_pkg::ADDR_SIG_CHANGE3:  hostReadData <= rxSigChange[31:24];
                rx_event_pkg::ADDR_SPARE_FIRST:  hostReadData <= sparePatternDefFirst;
                rx_event_pkg::ADDR_SPARE_SECOND: hostReadData <= sparePatternDefSecond;
                rx_event_pkg::ADDR_SUMMARY:      hostReadData <= rxInterruptSourceSummary;
                rx_event_pkg::ADDR_MASK_ONE:     hostReadData <= rxAlarmInterruptMask;
                rx_event_pkg::ADDR_MASK_TWO:     hostReadData <= rxE1FrameEventMask;
                rx_event_pkg::ADDR_MASK_FOUR:    hostReadData <= rxMaskFour;
                rx_event_pkg::ADDR_MASK_HDLC:    hostReadData <= rxMaskHdlc;
                rx_event_pkg::ADDR_MASK_CODE:    hostReadData <= rxMaskCode;
                rx_event_pkg::ADDR_SIG_ENABLE0:  hostReadData <= signalingChangeEnable[7:0];
                rx_event_pkg::ADDR_SIG_ENABLE1:  hostReadData <= signalingChangeEnable[15:8];
                rx_event_pkg::ADDR_SIG_ENABLE2:  hostReadData <= signalingChangeEnable[23:16];
                rx_event_pkg::ADDR_SIG_ENABLE3:  hostReadData <= signalingChangeEnable[31:24];
                default:                         hostReadData <= rx_event_pkg::READ_UNMAPPED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_readSigQuiet;
        readSig[0] && signalingToggle[7:0] == 8'h00;
    endsequence

    sequence s_spareWrite;
        hostWrite && hostAddr == rx_event_pkg::ADDR_SPARE_FIRST;
    endsequence

    property p_t1_multiframe;
        t1Mode && multiframeBoundary |=> rxLatchedStatusFour[0];
    endproperty
    a_t1_multiframe: assert property (p_t1_multiframe) else $error("T1 multiframe flag missed");

    property p_e1_free_multiframe;
        !t1Mode && !casEnabled && freeCount == 32'(MF_FREE_CYCLES - 1) && !$past(t1Mode)
            |=> rxLatchedStatusFour[0] && freeCount == 32'h0000_0000;
    endproperty
    a_e1_free_multiframe: assert property (p_e1_free_multiframe) else $error("free multiframe flag missed");

    property p_overrun;
        hdlcOverrunAbort |=> rxHdlcEventLatch[5];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not latched");

    property p_nonempty_edge;
        !hdlcFifoNonempty ##1 hdlcFifoNonempty |=> rxHdlcEventLatch[0];
    endproperty
    a_nonempty_edge: assert property (p_nonempty_edge) else $error("nonempty edge not latched");

    property p_level_no_reset;
        hdlcFifoNonempty && $past(hdlcFifoNonempty) && readHdlc |=> !rxHdlcEventLatch[0];
    endproperty
    a_level_no_reset: assert property (p_level_no_reset) else $error("nonempty level re-latched");

    property p_rai_gated;
        !rxCodeLinkEventLatch[5] && !(t1Mode && esfMode && remoteAlarmPresent) |=> !rxCodeLinkEventLatch[5];
    endproperty
    a_rai_gated: assert property (p_rai_gated) else $error("RAI-CI flag set without ESF alarm");

    property p_rss_clear;
        s_readSigQuiet |=> rxSigChange[7:0] == 8'h00;
    endproperty
    a_rss_clear: assert property (p_rss_clear) else $error("channel change bit not cleared by read");

    property p_spare_restart;
        s_spareWrite |=> spareIntegrationRestart ##1 !spareIntegrationRestart || $past(hostWrite);
    endproperty
    a_spare_restart: assert property (p_spare_restart) else $error("spare restart pulse wrong");

    property p_summary_masked;
        rxMaskHdlc == 8'h00 |-> !rxInterruptSourceSummary[4];
    endproperty
    a_summary_masked: assert property (p_summary_masked) else $error("masked bits reach summary");

    property p_interrupt_follows;
        ##1 interruptOutN == !$past(|rxInterruptSourceSummary);
    endproperty
    a_interrupt_follows: assert property (p_interrupt_follows) else $error("interrupt output mismatch");

endmodule : rx_event_status_interrupt_unit

`default_nettype wire

// File: rx_event_pkg.sv
// Constants for the receive event status and interrupt unit
// Overview of operation
// - T1 multiframe flag at each D4/ESF boundary
// - E1 multiframe flag every 2ms, free-runs without CAS; with CAS at each boundary
// - Latch overrun on abort for full FIFO
// - Latch first-byte flag at FIFO head
// - Packet-end on good or faulty finish; read-clear
// - Packet-start on opening byte; read-clear
// - High-watermark flag on rising above-mark edge
// - Nonempty flag on empty-to-nonempty edge only
// - RAI-CI flag only ESF and remote alarm
// - AIS-CI flag only while AIS present
// - SLC alignment flag when pattern and data ready
// - Bit-code detect and clear flags latched
// - E1 Sa6 codeword flag latched
// - E1 Sa change flag for selected bits
// - Per-channel signaling change bits, read-clear
// - Summary change flag for enabled channels, masked
// - Spare pattern from bit 7; short lengths ignore
// - Write first spare register restarts integration
// - Summary register flags pending status registers
// - Summary clears when no unmasked bit remains
// - Mask bit 1 enables, 0 masks; reset 0
// - Per-channel change enables, reset 0
`default_nettype none

package rx_event_pkg;

    localparam logic [7:0] ADDR_STATUS_FOUR  = 8'h93;
    localparam logic [7:0] ADDR_HDLC_EVENT   = 8'h94;
    localparam logic [7:0] ADDR_CODE_LINK    = 8'h96;
    localparam logic [7:0] ADDR_SIG_CHANGE0  = 8'h98;
    localparam logic [7:0] ADDR_SIG_CHANGE1  = 8'h99;
    localparam logic [7:0] ADDR_SIG_CHANGE2  = 8'h9A;
    localparam logic [7:0] ADDR_SIG_CHANGE3  = 8'h9B;
    localparam logic [7:0] ADDR_SPARE_FIRST  = 8'h9C;
    localparam logic [7:0] ADDR_SPARE_SECOND = 8'h9D;
    localparam logic [7:0] ADDR_SUMMARY      = 8'h9F;
    localparam logic [7:0] ADDR_MASK_ONE     = 8'hA0;
    localparam logic [7:0] ADDR_MASK_TWO     = 8'hA1;
    localparam logic [7:0] ADDR_MASK_FOUR    = 8'hA3;
    localparam logic [7:0] ADDR_MASK_HDLC    = 8'hA4;
    localparam logic [7:0] ADDR_MASK_CODE    = 8'hA6;
    localparam logic [7:0] ADDR_SIG_ENABLE0  = 8'hA8;
    localparam logic [7:0] ADDR_SIG_ENABLE1  = 8'hA9;
    localparam logic [7:0] ADDR_SIG_ENABLE2  = 8'hAA;
    localparam logic [7:0] ADDR_SIG_ENABLE3  = 8'hAB;

    // Implemented bits per register; reserved bits read zero
    localparam logic [7:0] USED_STATUS_FOUR = 8'h09;
    localparam logic [7:0] USED_MASK_FOUR   = 8'hEF;
    localparam logic [7:0] USED_MASK_TWO    = 8'h0F;
    localparam logic [7:0] USED_HDLC        = 8'h3F;
    localparam logic [7:0] USED_CODE_LINK   = 8'h3F;
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    localparam int BIT_MULTIFRAME   = 0;
    localparam int BIT_SIG_SUMMARY  = 3;
    localparam int BIT_OVERRUN      = 5;
    localparam int BIT_FIRST_BYTE   = 4;
    localparam int BIT_PACKET_END   = 3;
    localparam int BIT_PACKET_START = 2;
    localparam int BIT_HIGH_MARK    = 1;
    localparam int BIT_NONEMPTY     = 0;
    localparam int BIT_REMOTE_CI    = 5;
    localparam int BIT_AIS_CI       = 4;
    localparam int BIT_SLC_ALIGN    = 3;
    localparam int BIT_LINK_FULL    = 2;
    localparam int BIT_CODE_CLEAR   = 1;
    localparam int BIT_CODE_DETECT  = 0;
    localparam int BIT_SA6_CODEWORD = 1;
    localparam int BIT_SA_CHANGE    = 0;

    localparam int SUM_STATUS_ONE   = 0;
    localparam int SUM_STATUS_TWO   = 1;
    localparam int SUM_STATUS_THREE = 2;
    localparam int SUM_STATUS_FOUR  = 3;
    localparam int SUM_HDLC         = 4;
    localparam int SUM_CODE_LINK    = 6;

    localparam int CHANNELS       = 32;
    localparam int T1_CHANNELS    = 24;
    localparam int SA_BITS        = 5;
    localparam int SPARE_BITS     = 16;

    localparam int CLOCK_PERIOD_NS       = 5;
    localparam int E1_MULTIFRAME_MS_X10  = 20;
    localparam int E1_MULTIFRAME_CYCLES  = (E1_MULTIFRAME_MS_X10 * 100000) / CLOCK_PERIOD_NS;

endpackage : rx_event_pkg

`default_nettype wire

// File: rx_sticky_bank.sv
// Bank of sticky event flags cleared by a host read
`default_nettype none

module rx_sticky_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] setEvent,
    input  wire logic             readClear,
    output var  logic [WIDTH-1:0] status
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    status[i] <= 1'b0;
                end else if (setEvent[i]) begin
                    status[i] <= 1'b1;
                end else if (readClear) begin
                    status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    property p_set_wins;
        @(posedge clock) disable iff (!reset_n)
        (readClear && |setEvent) |=> (status & $past(setEvent)) == $past(setEvent);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost on clearing read");

endmodule : rx_sticky_bank

`default_nettype wire

// File: rx_event_status_interrupt_unit_tb.sv
// Self-checking bench for the receive event status and interrupt unit
`default_nettype none
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module rx_event_status_interrupt_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, resetN = 0, hostWrite = 0, hostRead = 0, t1Mode = 1, esfMode = 1, casEnabled = 1;
    logic        remoteAlarmPresent = 1, aisPresent = 1, slcDataReady = 1;
    logic [7:0]  hostAddr = 8'h00, hostWriteData = 8'h00, hostReadData;
    logic [14:0] ev = '0;
    logic [31:0] signalingToggle = '0;
    logic [4:0]  spareLength = 5'h00;
    logic [4:0]  saBitToggle = 5'h00, saBitSelectMask = 5'h00;
    logic [7:0]  latchedStatusTwo = 8'h00;
    logic [15:0] sparePattern, spareCareMask;
    logic        spareIntegrationRestart, interruptOutN;
    int          errCount = 0, samplesChecked = 0;
    // Pulse index, register, value expected after that pulse
    logic [19:0] tbl [15] = '{20'h0_94_20, 20'h1_94_10, 20'h2_94_08, 20'h3_94_08, 20'h4_94_04, 20'h5_94_02,
        20'h6_94_01, 20'h7_96_20, 20'h8_96_10, 20'h9_96_08, 20'hA_96_04, 20'hB_96_02, 20'hC_96_01,
        20'hD_96_02, 20'hE_93_01};

    always #2.5 clock = ~clock;

    rx_event_status_interrupt_unit #(.MF_FREE_CYCLES(20)) i_dut (.clock, .reset_n(resetN), .hostAddr, .hostWrite,
        .hostRead, .hostWriteData, .hostReadData, .t1Mode, .esfMode, .casEnabled, .multiframeBoundary(ev[14]),
        .hdlcOverrunAbort(ev[0]), .hdlcFirstByteAtHead(ev[1]), .hdlcPacketDone(ev[2]), .hdlcPacketFault(ev[3]),
        .hdlcOpeningByte(ev[4]), .hdlcAboveHighMark(ev[5]), .hdlcFifoNonempty(ev[6]), .remoteAlarmPresent,
        .raiCiPattern(ev[7]), .aisPresent, .aisCiPattern(ev[8]), .slcAlignFound(ev[9]), .slcDataReady,
        .dataLinkHoldingFull(ev[10]), .bitCodeValid(ev[12]), .bitCodeGone(ev[11]), .sa6Codeword(ev[13]),
        .saBitToggle, .saBitSelectMask, .signalingToggle, .latchedStatusOne(8'h00),
        .latchedStatusTwo, .statusThreePending(1'b0), .spareLength, .sparePattern, .spareCareMask,
        .spareIntegrationRestart, .interruptOutN);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc();
        @(posedge clock);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cyc();
        hostAddr = a;
        hostWriteData = v;
        hostWrite = 1;
        cyc();
        hostWrite = 0;
    endtask : wr

    // Read data lands on the same edge that takes the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        cyc();
        hostAddr = a;
        hostRead = 1;
        cyc();
        hostRead = 0;
        `CHK(hostReadData, e)
    endtask : rdc

    task automatic pl(input int i);
        cyc();
        ev[i] = 1;
        cyc();
        ev[i] = 0;
    endtask : pl

    task automatic conclude();
        $display("samples %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) cyc();
        resetN = 1;
        for (int a = 8'h93; a <= 8'hAB; a++) begin
            rdc(a[7:0], 8'h00);
        end
        foreach (tbl[k]) begin
            t1Mode = tbl[k][19:16] != 4'hD;
            pl(int'(tbl[k][19:16]));
            rdc(tbl[k][15:8], tbl[k][7:0]);
            rdc(tbl[k][15:8], 8'h00);
        end
        esfMode = 0;
        pl(7);
        rdc(8'h96, 8'h00);
        aisPresent = 0;
        pl(8);
        rdc(8'h96, 8'h00);
        // Level stays high across the clearing read
        ev[6] = 1;
        rdc(8'h94, 8'h01);
        rdc(8'h94, 8'h00);
        ev[6] = 0;
        wr(8'hA4, 8'hFF);
        rdc(8'hA4, 8'h3F);
        pl(0);
        rdc(8'h9F, 8'h10);
        `CHK(interruptOutN, 1'b0)
        rdc(8'h94, 8'h20);
        cyc();
        cyc();
        `CHK(interruptOutN, 1'b1)
        rdc(8'h9F, 8'h00);
        wr(8'hA4, 8'h00);
        pl(1);
        rdc(8'h9F, 8'h00);
        // Event lands in the same cycle as the clearing read
        cyc();
        hostAddr = 8'h94;
        hostRead = 1;
        ev[4] = 1;
        cyc();
        hostRead = 0;
        ev[4] = 0;
        `CHK(hostReadData, 8'h10)
        rdc(8'h94, 8'h04);
        wr(8'hA3, 8'h08);
        wr(8'hA8, 8'h04);
        cyc();
        signalingToggle = 32'h2000_0004;
        cyc();
        signalingToggle = '0;
        rdc(8'h98, 8'h04);
        rdc(8'h9B, 8'h00);
        `CHK(interruptOutN, 1'b0)
        rdc(8'h93, 8'h08);
        spareLength = 5'h04;
        wr(8'h9D, 8'h3C);
        wr(8'h9C, 8'hA5);
        `CHK(spareIntegrationRestart, 1'b1)
        cyc();
        `CHK(spareIntegrationRestart, 1'b0)
        cyc();
        `CHK({sparePattern, spareCareMask}, 32'hA000_F000)
        t1Mode = 0;
        casEnabled = 0;
        repeat (25) cyc();
        rdc(8'h93, 8'h01);
        saBitSelectMask = 5'h04;
        saBitToggle = 5'h02;
        cyc();
        saBitToggle = 5'h00;
        rdc(8'h96, 8'h00);
        saBitToggle = 5'h04;
        cyc();
        saBitToggle = 5'h00;
        rdc(8'h96, 8'h01);
        wr(8'hA1, 8'hFF);
        rdc(8'hA1, 8'h0F);
        latchedStatusTwo = 8'h02;
        rdc(8'h9F, 8'h02);
        `CHK(interruptOutN, 1'b0)
        t1Mode = 1;
        rdc(8'h9F, 8'h00);
        conclude();
    end

    initial begin
        #25000;
        errCount++;
        conclude();
    end
endmodule : rx_event_status_interrupt_unit_tb
`default_nettype wire
